// ==== sim/ibx_exec_test.sv ====
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("[ERR] %s expected %0h seen %0h", nm, e, g); \
  end \
end
module ibx_exec_test
  import ibx_pkg::*;
;
  // ---------------------------------------------------------------
  // bench signals and notes
  // ---------------------------------------------------------------
  typedef struct {int c; logic [14:0] v;} ibx_exp_t;
  localparam int TMO = 5000;
  logic i_clk, i_reset, i_ce, i_op_valid, i_dest, i_bus_wr, i_bus_rd;
  logic [2:0] i_opcode;
  logic [6:0] i_reg_addr, o_reg_waddr;
  logic [7:0] i_reg_data, i_bus_addr, i_bus_wdata, o_reg_wdata, o_acc;
  logic [7:0] o_bus_rdata;
  logic o_ready, o_reg_we, o_pc_load, o_discard, o_gie, o_zero;
  logic [10:0] o_pc_value;
  ibx_exp_t wq[$], pq[$], dq[$], rq[$];
  ibx_exp_t e, nx;
  logic [7:0] acc_m = 8'h00, th_m = 8'h00;
  logic [10:0] pc_m = 11'h000;
  logic z_m = 1'b0, gie_m = 1'b0, rd_pend = 1'b0;
  int cyc = 0, n_fail = 0, total_checks = 0;
  logic [7:0] bnd [6] = '{8'h01, 8'h00, 8'h80, 8'hFF, 8'h7F, 8'h00};

  ibx_exec ibx_exec_inst (
    .i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
    .i_op_valid(i_op_valid), .i_opcode(i_opcode), .i_dest(i_dest),
    .i_reg_addr(i_reg_addr), .i_reg_data(i_reg_data),
    .o_ready(o_ready), .o_reg_we(o_reg_we), .o_reg_waddr(o_reg_waddr),
    .o_reg_wdata(o_reg_wdata), .o_pc_load(o_pc_load),
    .o_pc_value(o_pc_value), .o_discard(o_discard), .o_gie(o_gie),
    .o_zero(o_zero), .o_acc(o_acc), .i_bus_addr(i_bus_addr),
    .i_bus_wdata(i_bus_wdata), .i_bus_wr(i_bus_wr), .i_bus_rd(i_bus_rd),
    .o_bus_rdata(o_bus_rdata)
  );

  // clock, 25 ns period
  always #12.5 i_clk = ~i_clk;

  // cycle count, read tracking and hang guard
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    rd_pend <= i_bus_rd & i_ce & ~i_reset;
    if (cyc >= TMO) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ---------------------------------------------------------------
  // monitor: oldest note against each result
  // ---------------------------------------------------------------
  always @(negedge i_clk) begin
    if (!i_reset) begin
      `CHK("acc", acc_m, o_acc)
      `CHK("zero flag", z_m, o_zero)
      `CHK("global enable", gie_m, o_gie)
      if (o_reg_we === 1'b1) begin
        e = nx;
        if (wq.size() > 0) e = wq.pop_front();
        `CHK("reg write", e.v, {o_reg_waddr, o_reg_wdata})
        `CHK("reg write cycle", e.c, cyc)
      end
      if (o_pc_load === 1'b1) begin
        e = nx;
        if (pq.size() > 0) e = pq.pop_front();
        `CHK("pc load", e.v[10:0], o_pc_value)
        `CHK("pc load cycle", e.c, cyc)
      end
      if (o_discard === 1'b1) begin
        e = nx;
        if (dq.size() > 0) e = dq.pop_front();
        `CHK("discard cycle", e.c, cyc)
      end
      if (rd_pend) begin
        e = nx;
        if (rq.size() > 0) e = rq.pop_front();
        `CHK("read data", e.v[7:0], o_bus_rdata)
      end
    end
  end

  // ---------------------------------------------------------------
  // drivers
  // ---------------------------------------------------------------
  task automatic run_op(input logic [2:0] opc, input logic d,
                        input logic [7:0] v);
    logic [6:0] a;
    logic [7:0] res;
    int n;
    int tc;
    a = 7'($urandom);
    n = 0;
    i_op_valid <= 1'b1;
    i_opcode <= opc;
    i_dest <= d;
    i_reg_addr <= a;
    i_reg_data <= v;
    i_bus_wr <= 1'b0;
    i_bus_rd <= 1'b0;
    @(negedge i_clk);
    while (o_ready !== 1'b1 && n < 8) begin
      @(negedge i_clk);
      n++;
    end
    `CHK("ready wait", 1'b1, o_ready)
    @(posedge i_clk);
    tc = cyc;
    res = (opc == OP_DECREMENT) ? v - 8'h01 : v + 8'h01;
    case (opc)
      OP_DECREMENT, OP_INCREMENT, OP_INCREMENT_SKIP_ZERO: begin
        if (d)
          wq.push_back('{tc + 1, {a, res}});
        else
          acc_m = res;
        if (opc != OP_INCREMENT_SKIP_ZERO)
          z_m = (res == 8'h00);
        else if (res == 8'h00)
          dq.push_back('{tc + 1, 15'h0000});
      end
      OP_GLOBAL_IRQ_OFF: gie_m = 1'b0;
      OP_GLOBAL_IRQ_ON: gie_m = 1'b1;
      OP_COMPUTED_BRANCH: begin
        pc_m = {th_m[2:0], acc_m};
        pq.push_back('{tc + 2, {4'h0, pc_m}});
      end
      default: ;
    endcase
  endtask : run_op

  // one bus cycle, write when w is high, else read
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    logic [7:0] r;
    i_op_valid <= 1'b0;
    i_bus_wr <= w;
    i_bus_rd <= ~w;
    i_bus_addr <= a;
    i_bus_wdata <= d;
    @(posedge i_clk);
    if (w) begin
      case (a)
        ADDR_ACC: acc_m = d;
        ADDR_TABLE_HIGH: th_m = d;
        ADDR_STATUS: {gie_m, z_m} = d[1:0];
        default: ;
      endcase
    end else begin
      case (a)
        ADDR_ACC: r = acc_m;
        ADDR_TABLE_HIGH: r = th_m;
        ADDR_STATUS: r = {6'h00, gie_m, z_m};
        ADDR_PC: r = pc_m[7:0];
        default: r = 8'h00;
      endcase
      rq.push_back('{0, {7'h00, r}});
    end
  endtask : bus

  task automatic chk_state();
    bus(1'b0, ADDR_STATUS, 8'h00);
    bus(1'b0, ADDR_ACC, 8'h00);
  endtask : chk_state

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] v;
    nx = '{-1, 'x};
    {i_clk, i_reset, i_ce} = 3'b011;
    {i_op_valid, i_dest, i_bus_wr, i_bus_rd} = 4'h0;
    {i_opcode, i_reg_addr, i_reg_data} = 18'h00000;
    {i_bus_addr, i_bus_wdata} = 16'h0000;
    void'($urandom(32'hA816FBF4));
    repeat (16) @(posedge i_clk);
    i_reset <= 1'b0;
    // reset state and an unmapped place
    chk_state();
    bus(1'b0, ADDR_PC, 8'h00);
    bus(1'b1, 8'h10, 8'hFF);
    bus(1'b0, 8'h10, 8'h00);
    $display("test reset_and_map done");
    // boundary then random increments and decrements
    for (int i = 0; i < 24; i++) begin
      v = (i < 12) ? bnd[i % 6] : 8'($urandom);
      if (i < 12)
        run_op((i % 6 < 3) ? OP_DECREMENT : OP_INCREMENT, 1'(i / 6), v);
      else
        run_op(3'($urandom_range(2, 1)), 1'($urandom), v);
      chk_state();
    end
    $display("test inc_dec done");
    // skip: flags untouched, back to back after a taken skip
    bus(1'b1, ADDR_STATUS, 8'h01);
    run_op(OP_INCREMENT_SKIP_ZERO, 1'b1, 8'h05);
    run_op(OP_INCREMENT_SKIP_ZERO, 1'b0, 8'hFF);
    run_op(OP_INCREMENT_SKIP_ZERO, 1'b1, 8'hFF);
    run_op(OP_INCREMENT, 1'b0, 8'h41);
    chk_state();
    bus(1'b1, ADDR_STATUS, 8'h00);
    run_op(OP_INCREMENT_SKIP_ZERO, 1'b0, 8'hFF);
    chk_state();
    run_op(OP_INCREMENT_SKIP_ZERO, 1'b1, 8'($urandom_range(254, 0)));
    chk_state();
    $display("test skip done");
    // global enable on and off, ignored codes between
    foreach (bnd[j]) begin
      run_op(3'(j == 1 ? 0 : j == 2 ? 7 : 4 + j % 2), 1'($urandom),
             8'($urandom));
      chk_state();
    end
    $display("test irq done");
    // clock enable low: held op and bus write change nothing
    i_ce <= 1'b0;
    i_op_valid <= 1'b1;
    i_opcode <= OP_GLOBAL_IRQ_OFF;
    i_bus_wr <= 1'b1;
    i_bus_rd <= 1'b0;
    i_bus_addr <= ADDR_ACC;
    i_bus_wdata <= ~acc_m;
    repeat (3) @(posedge i_clk);
    i_ce <= 1'b1;
    chk_state();
    $display("test clock_enable done");
    // computed branch, some followed at once by another op
    for (int k = 0; k < 6; k++) begin
      bus(1'b1, ADDR_TABLE_HIGH, k == 0 ? 8'hFD : 8'($urandom));
      bus(1'b1, ADDR_ACC, k == 0 ? 8'hFF : 8'($urandom));
      run_op(OP_COMPUTED_BRANCH, 1'b0, 8'($urandom));
      if (k % 2)
        run_op(OP_INCREMENT, 1'b0, 8'($urandom));
      bus(1'b0, ADDR_PC, 8'h00);
      bus(1'b0, ADDR_TABLE_HIGH, 8'h00);
      chk_state();
    end
    $display("test branch done");
    bus(1'b0, ADDR_ACC, 8'h00);
    i_bus_rd <= 1'b0;
    repeat (4) @(posedge i_clk);
    `CHK("writes left", 0, wq.size())
    `CHK("loads left", 0, pq.size())
    `CHK("discards left", 0, dq.size())
    `CHK("reads left", 0, rq.size())
    report_and_stop();
  end
endmodule : ibx_exec_test

// ==== verilog/ibx_exec.sv ====
`timescale 1ns/100ps
// Notes on behaviour
// - decrement register, result to acc or register
// - decrement of one stores zero, sets zero
// - increment register, result to acc or register
// - increment of FF wraps to zero, sets zero
// - irq off clears global enable bit
// - irq on sets global enable bit
// - branch loads pointer bits and acc, two cycles
// - increment skip stores result, flags untouched
// - zero skip result discards fetched next instruction
// - increment skip: one cycle, two on skip
module ibx_exec
  import ibx_pkg::*;
(
  input  wire logic         i_clk,        // core clock, 40 MHz
  input  wire logic         i_reset,      // sync reset, high
  input  wire logic         i_ce,         // clock enable
  input  wire logic         i_op_valid,   // decoded op present
  input  wire logic [2:0]   i_opcode,     // operation code
  input  wire logic         i_dest,       // 0 acc, 1 register
  input  wire logic [6:0]   i_reg_addr,   // addressed register
  input  wire logic [7:0]   i_reg_data,   // addressed reg value
  output logic              o_ready,      // op may be taken
  output logic              o_reg_we,     // register write pulse
  output logic      [6:0]   o_reg_waddr,  // register write addr
  output logic      [7:0]   o_reg_wdata,  // register write data
  output logic              o_pc_load,    // pc load pulse
  output logic      [10:0]  o_pc_value,   // pc load value
  output logic              o_discard,    // drop fetched op
  output logic              o_gie,        // global irq enable
  output logic              o_zero,       // zero flag
  output logic      [7:0]   o_acc,        // accumulator
  input  wire logic [7:0]   i_bus_addr,   // register address
  input  wire logic [7:0]   i_bus_wdata,  // register write data
  input  wire logic         i_bus_wr,     // write strobe
  input  wire logic         i_bus_rd,     // read strobe
  output logic      [7:0]   o_bus_rdata   // read data, next cycle
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  ibx_state_t state_r;
  ibx_state_t state_nxt;
  ibx_op_t op;
  logic [7:0] acc_r;
  logic [7:0] table_high_pointer_r;
  logic global_irq_enable_bit_r;
  logic zero_r;
  logic reg_we_r;
  logic [6:0] reg_waddr_r;
  logic [7:0] reg_wdata_r;
  logic pc_load_r;
  logic [10:0] pc_r;
  logic discard_r;
  logic [7:0] rdata_r;

  // ---------------------------------------------------------------
  // decode of the presented operation
  // ---------------------------------------------------------------
  logic accept;
  logic is_dec;
  logic is_inc;
  logic is_skip;
  logic is_arith;
  logic [7:0] alu_result;
  logic alu_zero;
  logic [10:0] pc_target;
  logic wr_acc_op;
  logic wr_reg_op;
  logic skip_taken;
  logic bus_wr_acc;
  logic bus_wr_tbl;
  logic bus_wr_status;

  // operation taken only when idle and enabled
  assign o_ready = (state_r == ST_IDLE);
  assign accept = i_ce & i_op_valid & o_ready;
  assign op = ibx_op_t'(i_opcode);
  assign is_dec = (op == OP_DECREMENT);
  assign is_inc = (op == OP_INCREMENT);
  assign is_skip = (op == OP_INCREMENT_SKIP_ZERO);
  assign is_arith = is_dec | is_inc | is_skip;

  // destination select for all three arithmetic ops
  assign wr_acc_op = accept & is_arith & ~i_dest;
  assign wr_reg_op = accept & is_arith & i_dest;
  assign skip_taken = accept & is_skip & alu_zero;

  // bus write decode
  assign bus_wr_acc = i_bus_wr & (i_bus_addr == ADDR_ACC);
  assign bus_wr_tbl = i_bus_wr & (i_bus_addr == ADDR_TABLE_HIGH);
  assign bus_wr_status = i_bus_wr & (i_bus_addr == ADDR_STATUS);

  // ---------------------------------------------------------------
  // datapath pieces
  // ---------------------------------------------------------------
  ibx_incdec ibx_incdec_inst (
    .i_operand   (i_reg_data),
    .i_decrement (is_dec),
    .o_result    (alu_result),
    .o_zero      (alu_zero)
  );

  ibx_pc_build ibx_pc_build_inst (
    .i_table_high (table_high_pointer_r),
    .i_acc        (acc_r),
    .o_pc         (pc_target)
  );

  // ---------------------------------------------------------------
  // sequencer for the two-cycle operations
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (accept && (op == OP_COMPUTED_BRANCH)) begin
          state_nxt = ST_BRANCH;
        end else if (skip_taken) begin
          state_nxt = ST_SKIP;
        end
      end
      ST_BRANCH: begin
        state_nxt = ST_IDLE;
      end
      ST_SKIP: begin
        state_nxt = ST_IDLE; // nop slot done
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_r <= ST_IDLE;
    end else if (i_ce) begin
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------------------------
  // accumulator: instruction result wins over bus write
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      acc_r <= ACC_RST;
    end else if (i_ce) begin
      if (wr_acc_op) begin
        acc_r <= alu_result;
      end else if (bus_wr_acc) begin
        acc_r <= i_bus_wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // zero flag: only plain increment and decrement, or a status write, touch it
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      zero_r <= ZERO_RST;
    end else if (i_ce) begin
      if (accept && (is_dec || is_inc)) begin
        zero_r <= alu_zero;
      end else if (bus_wr_status) begin
        zero_r <= i_bus_wdata[STATUS_ZERO_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // global interrupt enable
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      global_irq_enable_bit_r <= GIE_RST;
    end else if (i_ce) begin
      if (accept && (op == OP_GLOBAL_IRQ_OFF)) begin
        global_irq_enable_bit_r <= 1'b0;
      end else if (accept && (op == OP_GLOBAL_IRQ_ON)) begin
        global_irq_enable_bit_r <= 1'b1;
      end else if (bus_wr_status) begin
        global_irq_enable_bit_r <= i_bus_wdata[STATUS_GIE_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // table high pointer, software written
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      table_high_pointer_r <= TABLE_HIGH_RST;
    end else if (i_ce && bus_wr_tbl) begin
      table_high_pointer_r <= i_bus_wdata;
    end
  end

  // ---------------------------------------------------------------
  // register file write-back
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      reg_we_r <= 1'b0;
      reg_waddr_r <= 7'h00;
      reg_wdata_r <= 8'h00;
    end else if (i_ce) begin
      reg_we_r <= wr_reg_op;
      if (wr_reg_op) begin
        reg_waddr_r <= i_reg_addr;
        reg_wdata_r <= alu_result;
      end
    end
  end

  // ---------------------------------------------------------------
  // branch target captured on take, loaded on the second cycle
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pc_r <= PC_RST;
      pc_load_r <= 1'b0;
    end else if (i_ce) begin
      pc_load_r <= (state_r == ST_BRANCH);
      if (accept && (op == OP_COMPUTED_BRANCH)) begin
        pc_r <= pc_target;
      end
    end
  end

  // ---------------------------------------------------------------
  // discard pulse for the already fetched instruction
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      discard_r <= 1'b0;
    end else if (i_ce) begin
      discard_r <= skip_taken;
    end
  end

  // ---------------------------------------------------------------
  // register read port, data one cycle after strobe
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rdata_r <= 8'h00;
    end else if (i_ce) begin
      rdata_r <= 8'h00;
      if (i_bus_rd) begin
        unique case (i_bus_addr)
          ADDR_ACC: rdata_r <= acc_r;
          ADDR_TABLE_HIGH: rdata_r <= table_high_pointer_r;
          ADDR_STATUS: begin
            rdata_r[STATUS_ZERO_BIT] <= zero_r;
            rdata_r[STATUS_GIE_BIT] <= global_irq_enable_bit_r;
          end
          ADDR_PC: rdata_r <= pc_r[7:0];
          default: rdata_r <= 8'h00; // unmapped reads zero
        endcase
      end
    end
  end

  // outputs straight from flip-flops
  assign o_reg_we = reg_we_r;
  assign o_reg_waddr = reg_waddr_r;
  assign o_reg_wdata = reg_wdata_r;
  assign o_pc_load = pc_load_r;
  assign o_pc_value = pc_r;
  assign o_discard = discard_r;
  assign o_gie = global_irq_enable_bit_r;
  assign o_zero = zero_r;
  assign o_acc = acc_r;
  assign o_bus_rdata = rdata_r;

  // ---------------------------------------------------------------
  // checks, sampled only on enabled edges
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk iff i_ce);
  endclocking
  default disable iff (i_reset);

  property p_dec_acc;
    accept && is_dec && !i_dest |=>
      (acc_r == 8'($past(i_reg_data) - ONE)) && !o_reg_we;
  endproperty
  a_dec_acc: assert property (p_dec_acc)
    else $error("decrement to acc wrong");

  property p_dec_one;
    accept && is_dec && (i_reg_data == ONE) |=>
      zero_r && (o_reg_we ? (o_reg_wdata == 8'h00) : (acc_r == 8'h00));
  endproperty
  a_dec_one: assert property (p_dec_one)
    else $error("decrement of one not zero");

  property p_inc_reg;
    accept && is_inc && i_dest && !bus_wr_acc |=> o_reg_we &&
      (o_reg_wdata == 8'($past(i_reg_data) + ONE)) &&
      (o_reg_waddr == $past(i_reg_addr)) && $stable(acc_r);
  endproperty
  a_inc_reg: assert property (p_inc_reg)
    else $error("increment to register wrong");

  property p_inc_wrap;
    accept && is_inc && (i_reg_data == 8'hFF) |=>
      zero_r && (o_reg_we ? (o_reg_wdata == 8'h00) : (acc_r == 8'h00));
  endproperty
  a_inc_wrap: assert property (p_inc_wrap)
    else $error("increment of FF did not wrap");

  property p_irq_off;
    accept && (op == OP_GLOBAL_IRQ_OFF) |=> !o_gie;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("global enable not cleared");

  property p_irq_on;
    accept && (op == OP_GLOBAL_IRQ_ON) |=> o_gie;
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("global enable not set");

  property p_branch;
    accept && (op == OP_COMPUTED_BRANCH) |=> !o_ready && !o_pc_load
      ##1 o_ready && o_pc_load &&
      (o_pc_value == {$past(table_high_pointer_r[2:0], 2),
                      $past(acc_r, 2)});
  endproperty
  a_branch: assert property (p_branch)
    else $error("computed branch target or timing wrong");

  property p_skip_flags;
    accept && is_skip && !bus_wr_status |=> $stable(zero_r);
  endproperty
  a_skip_flags: assert property (p_skip_flags)
    else $error("increment skip changed zero flag");

  property p_skip_discard;
    accept && is_skip |=> (o_discard == ($past(i_reg_data) == 8'hFF));
  endproperty
  a_skip_discard: assert property (p_skip_discard)
    else $error("discard does not follow zero result");

  property p_skip_len;
    accept && is_skip && (i_reg_data == 8'hFF) |=> !o_ready ##1 o_ready;
  endproperty
  a_skip_len: assert property (p_skip_len)
    else $error("skip taken not two cycles");

  property p_noskip_len;
    accept && is_skip && (i_reg_data != 8'hFF) |=> o_ready && !o_discard;
  endproperty
  a_noskip_len: assert property (p_noskip_len)
    else $error("skip not taken not one cycle");

  property p_zero_clear;
    accept && (is_inc || is_dec) && !alu_zero |=> !zero_r;
  endproperty
  a_zero_clear: assert property (p_zero_clear)
    else $error("zero flag kept on nonzero result");

  c_branch: cover property (accept && (op == OP_COMPUTED_BRANCH) ##2 o_pc_load);
  c_skip: cover property (skip_taken ##1 o_discard);
  c_wrap: cover property (accept && is_inc && (i_reg_data == 8'hFF));
  c_irq: cover property (accept && (op == OP_GLOBAL_IRQ_ON) ##1 o_gie);

endmodule : ibx_exec

// ==== verilog/ibx_incdec.sv ====
`timescale 1ns/100ps
module ibx_incdec
  import ibx_pkg::*;
(
  input  wire logic [7:0] i_operand,   // register value
  input  wire logic       i_decrement, // 1 subtract, 0 add
  output logic      [7:0] o_result,    // modulo 256 result
  output logic            o_zero       // result is zero
);

  // ---------------------------------------------------------------
  // add or subtract one, wrapping at eight bits
  // ---------------------------------------------------------------
  always_comb begin
    if (i_decrement) begin
      o_result = 8'(i_operand - ONE);
    end else begin
      o_result = 8'(i_operand + ONE);
    end
    o_zero = ibx_is_zero(o_result);
  end

endmodule : ibx_incdec

// ==== verilog/ibx_pc_build.sv ====
`timescale 1ns/100ps
module ibx_pc_build
  import ibx_pkg::*;
(
  input  wire logic [7:0]  i_table_high, // table high pointer
  input  wire logic [7:0]  i_acc,        // accumulator
  output logic      [10:0] o_pc          // branch target
);

  // ---------------------------------------------------------------
  // high bits from pointer, low byte from accumulator
  // ---------------------------------------------------------------
  assign o_pc = {i_table_high[PC_HI_W-1:0], i_acc};

endmodule : ibx_pc_build

// ==== verilog/ibx_pkg.sv ====
package ibx_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int RADDR_W = 7;
  localparam int PC_W = 11;
  localparam int PC_HI_W = 3;

  // ---------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_ACC = 8'h00;
  localparam logic [7:0] ADDR_TABLE_HIGH = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_PC = 8'h0C;

  // ---------------------------------------------------------------
  // status fields and reset values
  // ---------------------------------------------------------------
  localparam int STATUS_ZERO_BIT = 0;
  localparam int STATUS_GIE_BIT = 1;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] TABLE_HIGH_RST = 8'h00;
  localparam logic [10:0] PC_RST = 11'h000;
  localparam logic ZERO_RST = 1'b0;
  localparam logic GIE_RST = 1'b0;
  localparam logic [7:0] ONE = 8'h01;

  // ---------------------------------------------------------------
  // cycle counts
  // ---------------------------------------------------------------
  localparam int BRANCH_CYCLES = 2;
  localparam int SKIP_TAKEN_CYCLES = 2;
  localparam int SKIP_NONE_CYCLES = 1;

  // ---------------------------------------------------------------
  // operation codes and sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_DECREMENT = 3'h1,
    OP_INCREMENT = 3'h2,
    OP_INCREMENT_SKIP_ZERO = 3'h3,
    OP_GLOBAL_IRQ_OFF = 3'h4,
    OP_GLOBAL_IRQ_ON = 3'h5,
    OP_COMPUTED_BRANCH = 3'h6
  } ibx_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BRANCH = 2'b01,
    ST_SKIP = 2'b10
  } ibx_state_t;

  // true when an eight-bit value is zero
  function automatic logic ibx_is_zero(input logic [7:0] v);
    ibx_is_zero = (v == 8'h00);
  endfunction : ibx_is_zero

endpackage : ibx_pkg
